/* File: hdl/ref_map.vh */
`ifndef REF_MAP_VH
`define REF_MAP_VH

// Protected configuration word layout
`define REF_CFG_INT_SEL      0
`define REF_CFG_EN_IO        1
`define REF_CFG_EN_UV        2
`define REF_CFG_EN_OV        3
`define REF_CFG_LIM_LO       4
`define REF_CFG_LIM_HI       6
`define REF_CFG_RST          8'h6E
// Codeword of the reset configuration, parity bits included
`define REF_CFG_CODE_RST     13'h0CF3

// Reset error counter thresholds and preload
`define REF_RERR_PRELOAD     3'h1
`define REF_RERR_INT_SEL0    3'h3
`define REF_RERR_FIN_SEL0    3'h6
`define REF_RERR_INT_SEL1    3'h1
`define REF_RERR_FIN_SEL1    3'h2

// Watchdog error counter
`define REF_WDERR_STEP       4'h2
`define REF_WDERR_LIMIT      4'h6

// Timing
`define REF_CLK_HZ           32'h0EE6_B280
`define REF_LONG_RST_SEC     32'h0000_0008
`define REF_LONG_RST_CYC     (`REF_LONG_RST_SEC * `REF_CLK_HZ)
`define REF_RST_HOLD_CYC     16'h0010

`endif

/* File: hdl/ref_hamming.v */
`include "ref_map.vh"

module ref_hamming (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        clk_en_in,
	input  wire        wr_in,
	input  wire [7:0]  wdata_in,
	input  wire        protect_in,
	input  wire        upset_in,
	input  wire [12:0] upset_mask_in,
	output wire [7:0]  data_out,
	output wire        single_out,
	output wire        double_out
);

	reg  [12:0] code_r;
	wire [3:0]  syn;
	wire        par;
	wire [12:0] fixed;

	function [3:0] syndrome;
		input [12:0] c;
		integer j;
		begin
			syndrome = 4'h0;
			for (j = 1; j < 13; j = j + 1) begin
				if (c[j])
					syndrome = syndrome ^ j[3:0];
			end
		end
	endfunction

	function [12:0] encode;
		input [7:0] d;
		reg   [3:0] s;
		begin
			encode = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 2'b00, 1'b0};
			s = syndrome(encode);
			encode[1] = s[0];
			encode[2] = s[1];
			encode[4] = s[2];
			encode[8] = s[3];
			encode[0] = ^encode[12:1];
		end
	endfunction

	assign syn   = syndrome(code_r);
	assign par   = ^code_r;
	assign fixed = par ? (code_r ^ (13'h0001 << syn)) : code_r;
	assign data_out   = {fixed[12:9], fixed[7:5], fixed[3]};
	assign single_out = protect_in & par;
	assign double_out = protect_in & ~par & (syn != 4'h0);

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			code_r <= `REF_CFG_CODE_RST;
		end else if (clk_en_in) begin
			if (wr_in)
				code_r <= encode(wdata_in);
			else if (upset_in)
				code_r <= code_r ^ upset_mask_in;
			else if (single_out)
				code_r <= encode(data_out);
		end
	end

endmodule // ref_hamming

/* File: hdl/ref_release_key.v */
module ref_release_key (
	input  wire [7:0] lfsr_in,
	input  wire [7:0] key_in,
	output wire       match_out
);

	wire [7:0] expect_key;

	// Bit order reversed, then every bit inverted
	assign expect_key = ~{lfsr_in[0], lfsr_in[1], lfsr_in[2], lfsr_in[3],
		lfsr_in[4], lfsr_in[5], lfsr_in[6], lfsr_in[7]};
	assign match_out  = (key_in == expect_key);

endmodule // ref_release_key

/* File: hdl/ref_failsafe_core.v */
`include "ref_map.vh"

module ref_failsafe_core #(
	parameter [31:0] LONG_RST_CYC = `REF_LONG_RST_CYC,
	parameter [15:0] RST_HOLD_CYC = `REF_RST_HOLD_CYC
) (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        clk_en_in,
	input  wire        init_phase_in,
	input  wire        low_power_off_mode_exit_in,
	input  wire        wake_input_zero_in,
	input  wire        wd_refresh_ok_in,
	input  wire        wd_refresh_bad_in,
	input  wire        wd_timeout_in,
	input  wire        wd_init_fail_in,
	input  wire        io_pair_fault_in,
	input  wire        undervoltage_in,
	input  wire        overvoltage_in,
	input  wire        bist_fail_in,
	input  wire        failsafe_stuck_high_in,
	input  wire        reset_stuck_high_in,
	input  wire        spi_reset_req_in,
	input  wire        ext_reset_in,
	input  wire        cfg_wr_in,
	input  wire [7:0]  cfg_data_in,
	input  wire        key_wr_in,
	input  wire [7:0]  key_data_in,
	input  wire [7:0]  watchdog_pseudo_random_word_in,
	input  wire        upset_in,
	input  wire [12:0] upset_mask_in,
	input  wire        flag_clear_in,
	output wire        reset_out_n,
	output wire        failsafe_out_n,
	output wire        regulators_off_out,
	output wire [2:0]  reset_err_count_out,
	output wire [3:0]  wd_err_count_out,
	output wire [2:0]  refresh_count_out,
	output wire [7:0]  cfg_out,
	output wire        single_err_flag_out,
	output wire        double_error_detect_out
);

	localparam [2:0] ST_RUN  = 3'b001;
	localparam [2:0] ST_RST  = 3'b010;
	localparam [2:0] ST_DEEP = 3'b100;

	reg  [2:0]  state_r;
	reg  [2:0]  state_nxt;
	reg  [2:0]  rerr_r;
	reg  [2:0]  rerr_nxt;
	reg  [3:0]  wderr_r;
	reg  [3:0]  wderr_nxt;
	reg  [2:0]  refr_r;
	reg  [2:0]  refr_nxt;
	reg  [15:0] hold_r;
	reg  [15:0] hold_nxt;
	reg  [31:0] long_r;
	reg  [31:0] long_nxt;
	reg         fs_act_r;
	reg         fs_act_nxt;
	reg         rst_n_r;
	reg         fs_n_r;
	reg         regoff_r;
	reg         sec_flag_r;
	reg         ded_flag_r;
	reg         io_prev_r;
	reg         uv_prev_r;
	reg         ov_prev_r;
	reg         fss_prev_r;
	reg         ext_prev_r;
	reg         wake_prev_r;
	reg         ded_prev_r;
	reg  [7:0]  cfg_q_r;

	wire [7:0]  cfg;
	wire        sec_pulse;
	wire        ded_pulse;
	wire        key_match;
	wire        int_sel;
	wire        en_io;
	wire        en_uv;
	wire        en_ov;
	wire [2:0]  refr_limit;
	wire        wd_fail;
	wire        wd_good;
	wire        wderr_hit;
	wire        dec_evt;
	wire        src_evt;
	wire        rst_evt;
	wire        wake_edge;
	wire        fault_now;
	wire        fault_set;
	wire        release_ok;
	wire        restart;

	function [2:0] inter_thr;
		input sel;
		begin
			inter_thr = sel ? `REF_RERR_INT_SEL1 : `REF_RERR_INT_SEL0;
		end
	endfunction

	function [2:0] final_thr;
		input sel;
		begin
			final_thr = sel ? `REF_RERR_FIN_SEL1 : `REF_RERR_FIN_SEL0;
		end
	endfunction

	function rise;
		input now;
		input prev;
		begin
			rise = now & ~prev;
		end
	endfunction

	// Configuration only accepted while init phase is open
	ref_hamming u_cfg (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.clk_en_in     (clk_en_in),
		.wr_in         (cfg_wr_in & init_phase_in),
		.wdata_in      (cfg_data_in),
		.protect_in    (~init_phase_in),
		.upset_in      (upset_in),
		.upset_mask_in (upset_mask_in),
		.data_out      (cfg),
		.single_out    (sec_pulse),
		.double_out    (ded_pulse)
	);

	ref_release_key u_key (
		.lfsr_in   (watchdog_pseudo_random_word_in),
		.key_in    (key_data_in),
		.match_out (key_match)
	);

	assign int_sel    = cfg[`REF_CFG_INT_SEL];
	assign en_io      = cfg[`REF_CFG_EN_IO];
	assign en_uv      = cfg[`REF_CFG_EN_UV];
	assign en_ov      = cfg[`REF_CFG_EN_OV];
	assign refr_limit = cfg[`REF_CFG_LIM_HI:`REF_CFG_LIM_LO];

	// Watchdog events only count while the reset is released
	assign wd_fail = state_r[1'b0] & (wd_refresh_bad_in | wd_timeout_in);
	assign wd_good = state_r[1'b0] & wd_refresh_ok_in & ~wd_fail;

	always @* begin
		wderr_nxt = wderr_r;
		if (wd_fail)
			wderr_nxt = (wderr_r >= `REF_WDERR_LIMIT - `REF_WDERR_STEP) ?
				`REF_WDERR_LIMIT : wderr_r + `REF_WDERR_STEP;
		else if (wd_good && wderr_r != 4'h0)
			wderr_nxt = wderr_r - 4'h1;
	end

	assign wderr_hit = wd_fail && (wderr_nxt == `REF_WDERR_LIMIT);

	always @* begin
		refr_nxt = refr_r;
		if (wd_fail)
			refr_nxt = 3'h0;
		else if (wd_good)
			refr_nxt = (refr_r >= refr_limit) ? 3'h0 : refr_r + 3'h1;
	end

	assign dec_evt = wd_good && (refr_r >= refr_limit);

	// Uncorrectable error counts once; it stays until rewritten
	assign src_evt = wderr_hit | wd_init_fail_in | wd_timeout_in
		| (en_io & rise(io_pair_fault_in, io_prev_r))
		| (en_uv & rise(undervoltage_in, uv_prev_r))
		| (en_ov & rise(overvoltage_in, ov_prev_r))
		| rise(failsafe_stuck_high_in, fss_prev_r)
		| rise(ded_pulse, ded_prev_r) | spi_reset_req_in
		| rise(ext_reset_in, ext_prev_r);

	// A new reset is generated only from the released state
	assign rst_evt   = state_r[0] & src_evt;
	assign wake_edge = rise(wake_input_zero_in, wake_prev_r);
	assign restart   = low_power_off_mode_exit_in | (state_r[2] & wake_edge);

	assign fault_now = (en_io & io_pair_fault_in) | (en_uv & undervoltage_in)
		| (en_ov & overvoltage_in) | bist_fail_in | reset_stuck_high_in
		| failsafe_stuck_high_in;
	assign fault_set = fault_now | ded_pulse;

	assign release_ok = key_wr_in & key_match & ~fault_now & ~ded_pulse
		& (rerr_r == 3'h0) & ~state_r[2];

	always @* begin
		rerr_nxt = rerr_r;
		if (restart)
			rerr_nxt = `REF_RERR_PRELOAD;
		else if (rst_evt)
			rerr_nxt = (rerr_r >= final_thr(int_sel)) ?
				final_thr(int_sel) : rerr_r + 3'h1;
		else if (dec_evt && rerr_r != 3'h0)
			rerr_nxt = rerr_r - 3'h1;
	end

	always @* begin
		state_nxt = state_r;
		hold_nxt  = hold_r;
		long_nxt  = long_r;
		case (state_r)
			ST_RUN: begin
				long_nxt = 32'h0000_0000;
				if (rst_evt) begin
					hold_nxt = 16'h0000;
					if (rerr_nxt >= final_thr(int_sel))
						state_nxt = ST_DEEP;
					else
						state_nxt = ST_RST;
				end
			end
			ST_RST: begin
				if (hold_r < RST_HOLD_CYC)
					hold_nxt = hold_r + 16'h0001;
				if (long_r >= LONG_RST_CYC)
					state_nxt = ST_DEEP;
				else begin
					long_nxt = long_r + 32'h0000_0001;
					if (hold_r >= RST_HOLD_CYC && !ext_reset_in)
						state_nxt = ST_RUN;
				end
			end
			ST_DEEP: begin
				hold_nxt = 16'h0000;
				long_nxt = 32'h0000_0000;
			end
			default: begin
				state_nxt = ST_RST;
				hold_nxt  = 16'h0000;
				long_nxt  = 32'h0000_0000;
			end
		endcase
		if (restart) begin
			state_nxt = ST_RST;
			hold_nxt  = 16'h0000;
			long_nxt  = 32'h0000_0000;
		end
	end

	// Set beats release in the same cycle
	always @* begin
		fs_act_nxt = fs_act_r;
		if (release_ok)
			fs_act_nxt = 1'b0;
		if (restart || fault_set || (rerr_nxt >= inter_thr(int_sel)))
			fs_act_nxt = 1'b1;
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r  <= ST_RST;
			rerr_r   <= `REF_RERR_PRELOAD;
			wderr_r  <= 4'h0;
			refr_r   <= 3'h0;
			hold_r   <= 16'h0000;
			long_r   <= 32'h0000_0000;
			fs_act_r <= 1'b1;
			rst_n_r  <= 1'b0;
			fs_n_r   <= 1'b0;
			regoff_r <= 1'b0;
			cfg_q_r  <= `REF_CFG_RST;
		end else if (clk_en_in) begin
			state_r  <= state_nxt;
			rerr_r   <= rerr_nxt;
			wderr_r  <= wderr_hit ? 4'h0 : wderr_nxt;
			refr_r   <= refr_nxt;
			hold_r   <= hold_nxt;
			long_r   <= long_nxt;
			fs_act_r <= fs_act_nxt;
			rst_n_r  <= ~(state_nxt[1] | state_nxt[2]);
			fs_n_r   <= ~(fs_act_nxt | state_nxt[2]);
			regoff_r <= state_nxt[2];
			cfg_q_r  <= cfg;
		end
	end

	// Sticky upset flags, set wins over clear
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sec_flag_r <= 1'b0;
			ded_flag_r <= 1'b0;
		end else if (clk_en_in) begin
			sec_flag_r <= sec_pulse | (sec_flag_r & ~flag_clear_in);
			ded_flag_r <= ded_pulse | (ded_flag_r & ~flag_clear_in);
		end
	end

	// Edge detection on level fault, external reset, wake and double-error inputs
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			io_prev_r   <= 1'b0;
			uv_prev_r   <= 1'b0;
			ov_prev_r   <= 1'b0;
			fss_prev_r  <= 1'b0;
			ext_prev_r  <= 1'b0;
			wake_prev_r <= 1'b0;
			ded_prev_r  <= 1'b0;
		end else if (clk_en_in) begin
			io_prev_r   <= io_pair_fault_in;
			uv_prev_r   <= undervoltage_in;
			ov_prev_r   <= overvoltage_in;
			fss_prev_r  <= failsafe_stuck_high_in;
			ext_prev_r  <= ext_reset_in;
			wake_prev_r <= wake_input_zero_in;
			ded_prev_r  <= ded_pulse;
		end
	end

	assign reset_out_n             = rst_n_r;
	assign failsafe_out_n          = fs_n_r;
	assign regulators_off_out      = regoff_r;
	assign reset_err_count_out     = rerr_r;
	assign wd_err_count_out        = wderr_r;
	assign refresh_count_out       = refr_r;
	assign cfg_out                 = cfg_q_r;
	assign single_err_flag_out     = sec_flag_r;
	assign double_error_detect_out = ded_flag_r;

endmodule // ref_failsafe_core

/* File: bench/ref_host_model.sv */
module ref_host_model (
	input  logic       clk_in,
	input  logic [7:0] word_in,
	output logic       ok_out,
	output logic       bad_out,
	output logic       key_wr_out,
	output logic [7:0] key_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ok_out = 1'b0;
		bad_out = 1'b0;
		key_wr_out = 1'b0;
		key_out = 8'h00;
	end
	// One refresh pulse after an optional idle gap
	task automatic refresh(input logic good, input int gap);
		repeat (gap) @(negedge clk_in);
		@(negedge clk_in);
		ok_out = good;
		bad_out = !good;
		@(negedge clk_in);
		ok_out = 1'b0;
		bad_out = 1'b0;
	endtask
	task automatic send_key(input logic right);
		@(negedge clk_in);
		key_out = ~{word_in[0], word_in[1], word_in[2], word_in[3],
			word_in[4], word_in[5], word_in[6], word_in[7]} ^ {7'h00, !right};
		key_wr_out = 1'b1;
		@(negedge clk_in);
		key_wr_out = 1'b0;
		key_out = ~key_out;
	endtask
endmodule // ref_host_model

/* File: bench/ref_failsafe_monitor.sv */
module ref_failsafe_monitor (
	input logic        clk_in,
	input logic        rst_in,
	input logic        clk_en_in,
	input logic        init_phase_in,
	input logic        low_power_off_mode_exit_in,
	input logic        wake_input_zero_in,
	input logic        wd_refresh_bad_in,
	input logic        wd_timeout_in,
	input logic        spi_reset_req_in,
	input logic        cfg_wr_in,
	input logic        key_wr_in,
	input logic [7:0]  key_data_in,
	input logic [7:0]  watchdog_pseudo_random_word_in,
	input logic        upset_in,
	input logic [12:0] upset_mask_in,
	input logic        reset_out_n,
	input logic        failsafe_out_n,
	input logic        regulators_off_out,
	input logic [2:0]  reset_err_count_out,
	input logic [3:0]  wd_err_count_out,
	input logic [7:0]  cfg_out,
	input logic        single_err_flag_out,
	input logic        double_error_detect_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	wire [2:0] fin = cfg_out[0] ? 3'h2 : 3'h6;
	wire [2:0] mid = cfg_out[0] ? 3'h1 : 3'h3;
	wire [7:0] w   = watchdog_pseudo_random_word_in;
	wire [7:0] rev = {w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7]};
	wire       run = reset_out_n && !regulators_off_out && clk_en_in;
	logic      key_ok_r;
	always @(posedge clk_in) key_ok_r <= key_wr_in && key_data_in == ~rev && reset_err_count_out == 3'h0;
	sequence s_spi;
		run && spi_reset_req_in && reset_err_count_out < fin;
	endsequence
	sequence s_ded;
		run && upset_in && !init_phase_in && $countones(upset_mask_in) == 2;
	endsequence
	AST_RERR_INC: assert property (s_spi |=> reset_err_count_out == $past(reset_err_count_out) + 3'h1 && !reset_out_n) else $error("reset event did not count");
	AST_MID_FS: assert property (reset_err_count_out >= mid |-> !failsafe_out_n) else $error("fail-safe high at intermediate count");
	AST_FIN_DEEP: assert property ($rose(reset_err_count_out >= fin) |-> ##[0:1] regulators_off_out) else $error("final count without deep state");
	AST_DEEP_PINS: assert property (regulators_off_out |-> !reset_out_n && !failsafe_out_n) else $error("deep state outputs released");
	AST_DEEP_HOLD: assert property (regulators_off_out && !low_power_off_mode_exit_in && !wake_input_zero_in |=> regulators_off_out) else $error("deep state left without wake");
	AST_KEY_REL: assert property ($rose(failsafe_out_n) |-> key_ok_r) else $error("fail-safe released without key");
	AST_SAT: assert property (reset_err_count_out <= fin) else $error("reset error count above final");
	AST_WD_STEP: assert property (run && wd_refresh_bad_in && !wd_timeout_in && wd_err_count_out < 4'h4 |=> wd_err_count_out == $past(wd_err_count_out) + 4'h2) else $error("watchdog error step wrong");
	AST_SEC: assert property (clk_en_in && upset_in && !init_phase_in && $countones(upset_mask_in) == 1 |=> $stable(cfg_out) ##1 single_err_flag_out) else $error("single upset not corrected");
	AST_DED: assert property (s_ded |=> ##1 double_error_detect_out && !failsafe_out_n ##[0:1] !reset_out_n) else $error("double upset not handled");
	AST_CFG_LOCK: assert property (cfg_wr_in && !init_phase_in && !upset_in |=> $stable(cfg_out)) else $error("config written outside init");
	AST_LOW_POWER_OFF_MODE: assert property (clk_en_in && low_power_off_mode_exit_in |=> reset_err_count_out == 3'h1
		&& !reset_out_n && !failsafe_out_n) else $error("low power exit not preloaded");
endmodule // ref_failsafe_monitor

bind ref_failsafe_core ref_failsafe_monitor u_mon (.*);

/* File: bench/testbench.sv */
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in, rst_in, init, wake, bist, upset, cfg_wr, ok, bad, key_wr;
	logic        clk_en, low_power_off_mode, rstuck, flag_clr;
	logic [7:0]  src, cfg_d, key_d, lfsr;
	logic [12:0] mask;
	wire         reset_out_n, failsafe_out_n, regs_off, sec, ded;
	wire [2:0]   rerr, rcnt;
	wire [3:0]   wderr;
	wire [7:0]   cfg;
	int          n_fail = 0;
	int          num_checks = 0;
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	ref_host_model u_host (.clk_in(clk_in), .word_in(lfsr), .ok_out(ok), .bad_out(bad),
		.key_wr_out(key_wr), .key_out(key_d));
	ref_failsafe_core #(.LONG_RST_CYC(32'd40), .RST_HOLD_CYC(16'd4)) uut (
		.clk_in(clk_in), .rst_in(rst_in), .clk_en_in(clk_en), .init_phase_in(init),
		.low_power_off_mode_exit_in(low_power_off_mode), .wake_input_zero_in(wake), .wd_refresh_ok_in(ok),
		.wd_refresh_bad_in(bad), .wd_timeout_in(src[5]), .wd_init_fail_in(src[4]),
		.io_pair_fault_in(src[6]), .undervoltage_in(src[2]), .overvoltage_in(src[3]),
		.bist_fail_in(bist), .failsafe_stuck_high_in(src[7]), .reset_stuck_high_in(rstuck),
		.spi_reset_req_in(src[0]), .ext_reset_in(src[1]), .cfg_wr_in(cfg_wr),
		.cfg_data_in(cfg_d), .key_wr_in(key_wr), .key_data_in(key_d),
		.watchdog_pseudo_random_word_in(lfsr), .upset_in(upset), .upset_mask_in(mask),
		.flag_clear_in(flag_clr), .reset_out_n(reset_out_n), .failsafe_out_n(failsafe_out_n),
		.regulators_off_out(regs_off), .reset_err_count_out(rerr), .wd_err_count_out(wderr),
		.refresh_count_out(rcnt), .cfg_out(cfg), .single_err_flag_out(sec),
		.double_error_detect_out(ded));
	task automatic complete_run;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wait_run;
		for (int i = 0; i < 200 && reset_out_n !== 1'b1; i++) @(negedge clk_in);
		if (reset_out_n !== 1'b1) begin
			n_fail++;
			complete_run;
		end
	endtask
	task automatic pulse(input int b);
		@(negedge clk_in);
		src[b] = 1'b1;
		@(negedge clk_in);
		src[b] = 1'b0;
	endtask
	task automatic poke(input logic [12:0] m);
		@(negedge clk_in);
		upset = 1'b1;
		mask = m;
		@(negedge clk_in);
		upset = 1'b0;
	endtask
	task automatic cfg_write(input logic [7:0] d);
		@(negedge clk_in);
		cfg_wr = 1'b1;
		cfg_d = d;
		@(negedge clk_in);
		cfg_wr = 1'b0;
	endtask
	initial begin
		{rst_in, init, wake, bist, upset, cfg_wr, src, mask} = {6'b110000, 8'h00, 13'h0000};
		cfg_d = 8'h00;
		{clk_en, low_power_off_mode, rstuck, flag_clr} = 4'b1000;
		lfsr = 8'hB2;
		repeat (20) @(negedge clk_in);
		`CHK(rerr, 3'h1)
		`CHK(failsafe_out_n, 1'b0)
		rst_in = 1'b0;
		wait_run;
		cfg_write(8'h6E);
		init = 1'b0;
		cfg_write(8'h6F);
		`CHK(cfg, 8'h6E)
		for (int i = 0; i < 7; i++) begin
			u_host.refresh(1'b1, i % 3);
			if (i == 5) `CHK(rcnt, 3'h6)
		end
		`CHK(rerr, 3'h0)
		`CHK(rcnt, 3'h0)
		u_host.send_key(1'b0);
		`CHK(failsafe_out_n, 1'b0)
		lfsr = 8'h5A;
		rstuck = 1'b1;
		u_host.send_key(1'b1);
		`CHK(failsafe_out_n, 1'b0)
		rstuck = 1'b0;
		u_host.send_key(1'b1);
		`CHK(failsafe_out_n, 1'b1)
		bist = 1'b1;
		@(negedge clk_in);
		`CHK(failsafe_out_n, 1'b0)
		bist = 1'b0;
		u_host.refresh(1'b0, 0);
		`CHK(wderr, 4'h2)
		u_host.refresh(1'b1, 1);
		`CHK(wderr, 4'h1)
		`CHK(rcnt, 3'h1)
		clk_en = 1'b0;
		pulse(0);
		`CHK(rerr, 3'h0)
		`CHK(reset_out_n, 1'b1)
		clk_en = 1'b1;
		poke(13'h0004);
		@(negedge clk_in);
		`CHK(sec, 1'b1)
		`CHK(cfg, 8'h6E)
		for (int b = 0; b < 6; b++) begin
			pulse(b);
			`CHK(rerr, b[2:0] + 3'h1)
			if (b < 5) wait_run;
		end
		`CHK(regs_off, 1'b1)
		@(negedge clk_in);
		wake = 1'b1;
		@(negedge clk_in);
		wake = 1'b0;
		`CHK(regs_off, 1'b0)
		`CHK(rerr, 3'h1)
		wait_run;
		pulse(6);
		wait_run;
		pulse(7);
		`CHK(rerr, 3'h3)
		wait_run;
		poke(13'h0006);
		repeat (2) @(negedge clk_in);
		`CHK(ded, 1'b1)
		`CHK(reset_out_n, 1'b0)
		wait_run;
		src[1] = 1'b1;
		repeat (60) @(negedge clk_in);
		`CHK(regs_off, 1'b1)
		src[1] = 1'b0;
		flag_clr = 1'b1;
		@(negedge clk_in);
		flag_clr = 1'b0;
		`CHK(sec, 1'b0)
		`CHK(ded, 1'b1)
		low_power_off_mode = 1'b1;
		@(negedge clk_in);
		low_power_off_mode = 1'b0;
		`CHK(regs_off, 1'b0)
		`CHK(rerr, 3'h1)
		`CHK(failsafe_out_n, 1'b0)
		rst_in = 1'b1;
		init = 1'b1;
		@(negedge clk_in);
		rst_in = 1'b0;
		`CHK(rerr, 3'h1)
		wait_run;
		cfg_write(8'h6F);
		init = 1'b0;
		@(negedge clk_in);
		`CHK(cfg, 8'h6F)
		pulse(0);
		`CHK(rerr, 3'h2)
		`CHK(regs_off, 1'b1)
		complete_run;
	end
endmodule // testbench
